//--- include/pmil_defines.vh
// Register map, field positions and timing counts of the PHY management logic
`ifndef PMIL_DEFINES_VH
`define PMIL_DEFINES_VH

// Register numbers on the management link
`define PMIL_REG_BCTL     5'h00
`define PMIL_REG_BSTAT    5'h01
`define PMIL_REG_LPABIL   5'h05
`define PMIL_REG_ANEXP    5'h06
`define PMIL_REG_EDPDCFG  5'h10
`define PMIL_REG_MODECS   5'h11
`define PMIL_REG_SPECIND  5'h1b
`define PMIL_REG_FLAGS    5'h1d
`define PMIL_REG_ENABLES  5'h1e
`define PMIL_REG_WAKECS   5'h1f

// Basic control fields
`define PMIL_BCTL_DUPLEX  8
`define PMIL_BCTL_RSTAN   9
`define PMIL_BCTL_ANEN    12
`define PMIL_BCTL_SPEED   13
`define PMIL_BCTL_RESET   16'h3000

// Basic status fields
`define PMIL_BSTAT_LINK   2
`define PMIL_BSTAT_RFLT   4
`define PMIL_BSTAT_ANDONE 5
`define PMIL_BSTAT_FIXED  16'h7800

// Mode control/status fields
`define PMIL_MODE_ENERGY  1
`define PMIL_MODE_ALT_IRQ_SELECT  6
`define PMIL_MODE_EDPD    13
`define PMIL_MODE_RESET   16'h0002

// Special indication fields
`define PMIL_SPEC_XSTATE  13
`define PMIL_SPEC_XEN     14
`define PMIL_SPEC_XOVR    15

// Crossover config fields
`define PMIL_EDPD_XEXT    0
`define PMIL_EDPD_MEXT    1

// Flag bit positions
`define PMIL_F_PAGE       1
`define PMIL_F_PDF        2
`define PMIL_F_ACK        3
`define PMIL_F_LDOWN      4
`define PMIL_F_RFLT       5
`define PMIL_F_ANDONE     6
`define PMIL_F_ENERGY     7
`define PMIL_F_WAKE       8
`define PMIL_F_LUP        9

// Read value of an unsupported register
`define PMIL_UNSUP        16'hffff

// Management frame fields
`define PMIL_OP_WRITE     2'b01
`define PMIL_OP_READ      2'b10

// Energy late pulse timing
`define PMIL_ELATE_MS     1000
`define PMIL_EPULSE_MS    256
`define PMIL_CLK_KHZ      125000

`endif

//--- rtl/pmil_sync.v
// Two-flop synchroniser for one pin level
module pmil_sync (
    // Clock and reset
    input  wire i_clk,
    input  wire i_srst,
    // Level in and out
    input  wire i_async,
    output reg  o_sync
);

    reg stage1;

    // First flop feeds second only
    always @(posedge i_clk) begin
        if (i_srst) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule // pmil_sync

//--- rtl/pmil_mdio.v
// Clause 22 serial management slave framing, sampled on the system clock
`include "pmil_defines.vh"
module pmil_mdio #(
    parameter [4:0] PHY_ADDR = 5'h01
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // Synchronised link pins
    input  wire        i_mdc,
    input  wire        i_mdio,
    output reg         o_mdio,
    output reg         o_mdio_oe,
    // Register side
    output reg         o_rd,
    output reg         o_wr,
    output reg  [4:0]  o_reg,
    output reg  [15:0] o_wdata,
    input  wire [15:0] i_rdata
);

    localparam S_IDLE = 2'd0;
    localparam S_HEAD = 2'd1;
    localparam S_DATA = 2'd2;

    reg [1:0]  state;
    reg        mdc_q;
    reg [5:0]  cnt;
    reg [31:0] sh;
    reg        is_rd;
    reg [15:0] rsh;
    wire       rise = i_mdc & ~mdc_q;
    wire       fall = ~i_mdc & mdc_q;
    wire [31:0] shn = {sh[30:0], i_mdio};

    // Frame engine: preamble, start, op, addresses, turnaround, data
    always @(posedge i_clk) begin
        if (i_srst) begin
            state     <= S_IDLE;
            mdc_q     <= 1'b0;
            cnt       <= 6'd0;
            sh        <= 32'h0000_0000;
            is_rd     <= 1'b0;
            rsh       <= 16'h0000;
            o_mdio    <= 1'b1;
            o_mdio_oe <= 1'b0;
            o_rd      <= 1'b0;
            o_wr      <= 1'b0;
            o_reg     <= 5'h00;
            o_wdata   <= 16'h0000;
        end else begin
            mdc_q <= i_mdc;
            o_rd  <= 1'b0;
            o_wr  <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (rise) begin
                        sh <= shn;
                        // Preamble ones then start 01
                        if (shn[1:0] == 2'b01 && sh[31:1] == 31'h7fff_ffff) begin
                            state <= S_HEAD;
                            cnt   <= 6'd0;
                        end
                    end
                end
                S_HEAD: begin
                    if (rise) begin
                        sh  <= shn;
                        cnt <= cnt + 6'd1;
                        if (cnt == 6'd11) begin
                            o_reg <= shn[4:0];
                            if (shn[9:5] != PHY_ADDR) begin
                                state <= S_IDLE;
                                sh    <= 32'h0000_0000;
                            end else if (shn[11:10] == `PMIL_OP_READ) begin
                                is_rd <= 1'b1;
                                o_rd  <= 1'b1;
                                state <= S_DATA;
                                cnt   <= 6'd0;
                            end else if (shn[11:10] == `PMIL_OP_WRITE) begin
                                is_rd <= 1'b0;
                                state <= S_DATA;
                                cnt   <= 6'd0;
                            end else begin
                                state <= S_IDLE;
                                sh    <= 32'h0000_0000;
                            end
                        end
                    end
                end
                S_DATA: begin
                    // Turnaround plus sixteen data bits
                    if (is_rd) begin
                        // Latch once, before a clear-on-read lands
                        if (o_rd) begin
                            rsh <= i_rdata;
                        end
                        if (fall) begin
                            cnt <= cnt + 6'd1;
                            if (cnt == 6'd1) begin
                                o_mdio_oe <= 1'b1;
                                o_mdio    <= 1'b0;
                            end else if (cnt >= 6'd2 && cnt <= 6'd17) begin
                                o_mdio <= rsh[15];
                                rsh    <= {rsh[14:0], 1'b0};
                            end else if (cnt == 6'd18) begin
                                o_mdio_oe <= 1'b0;
                                o_mdio    <= 1'b1;
                                state     <= S_IDLE;
                                sh        <= 32'h0000_0000;
                            end
                        end
                    end else if (rise) begin
                        sh  <= shn;
                        cnt <= cnt + 6'd1;
                        if (cnt == 6'd17) begin
                            o_wdata <= shn[15:0];
                            o_wr    <= 1'b1;
                            state   <= S_IDLE;
                            sh      <= 32'h0000_0000;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule // pmil_mdio

//--- rtl/pmil_top.v
// PHY management register file, mode control and interrupt flag logic
`include "pmil_defines.vh"
module pmil_top #(
    parameter [4:0]  PHY_ADDR     = 5'h01,
    parameter        XOVR_DIS_IDX = 0,
    parameter [31:0] ELATE_CYC    = `PMIL_ELATE_MS * `PMIL_CLK_KHZ,
    parameter [31:0] EPULSE_CYC   = `PMIL_EPULSE_MS * `PMIL_CLK_KHZ
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // Management link pins
    input  wire        i_mdc,
    input  wire        i_mdio,
    output wire        o_mdio,
    output wire        o_mdio_oe,
    // Hardware configuration straps
    input  wire [1:0]  i_xovr_disable,
    // PHY status inputs from the line logic
    input  wire        i_link_state,
    input  wire        i_energy,
    input  wire        i_an_done,
    input  wire        i_remote_fault,
    input  wire        i_lp_ack,
    input  wire        i_pd_fault,
    input  wire        i_page_rx,
    input  wire [7:0]  i_wake_ctrl,
    // MAC side activity
    input  wire        i_tx_active,
    input  wire        i_rx_active,
    // Resolved mode outputs
    output reg         o_speed_100,
    output reg         o_full_duplex,
    output reg         o_crs,
    output reg         o_col,
    output reg         o_xovr_enable,
    output reg         o_xovr_state,
    output reg         o_xovr_extend,
    output reg         o_an_restart,
    // Interrupt line to system controller
    output reg         o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and synchronised pins
    reg  [15:0] basic_control_reg;
    reg  [15:0] mode_ctrl_status_reg;
    reg  [15:0] special_ctrl_status_ind_reg;
    reg  [15:0] energy_powerdown_cfg_reg;
    reg  [15:0] irq_enable_reg;
    reg  [15:0] irq_flag_reg;
    reg  [15:0] next_flags;
    reg  [15:0] rdata;
    reg  [9:0]  src_q;
    reg  [2:0]  settle;
    reg         strap_done;
    reg         hw_xovr_en;
    reg         energy_seen;
    reg  [31:0] late_cnt;
    reg  [31:0] pulse_cnt;
    reg         late_armed;
    wire        mdc_s;
    wire        mdio_s;
    wire        rd;
    wire        wr;
    wire [4:0]  reg_num;
    wire [15:0] wdata;
    wire [9:0]  src_s;
    wire [9:0]  src_raw;
    wire [9:0]  rise;
    wire [9:0]  fall;
    wire [9:0]  deassert_ok;
    wire        wake_event_summary;
    wire        alt_irq_select;
    wire        rd_flags;
    wire        rd_bstat;
    wire        rd_anexp;
    wire        restart;
    wire        pulse_on;

    pmil_sync u_sync_mdc (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_async (i_mdc),
        .o_sync  (mdc_s)
    );

    pmil_sync u_sync_mdio (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_async (i_mdio),
        .o_sync  (mdio_s)
    );

    pmil_mdio #(
        .PHY_ADDR (PHY_ADDR)
    ) u_mdio (
        .i_clk     (i_clk),
        .i_srst    (i_srst),
        .i_mdc     (mdc_s),
        .i_mdio    (mdio_s),
        .o_mdio    (o_mdio),
        .o_mdio_oe (o_mdio_oe),
        .o_rd      (rd),
        .o_wr      (wr),
        .o_reg     (reg_num),
        .o_wdata   (wdata),
        .i_rdata   (rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event sources, synchronised per bit
    assign wake_event_summary = |(i_wake_ctrl[7:4] & i_wake_ctrl[3:0]);
    assign src_raw = {i_link_state, wake_event_summary, i_energy,
                      i_an_done, i_remote_fault, ~i_link_state,
                      i_lp_ack, i_pd_fault, i_page_rx, 1'b0};

    genvar g;
    generate
        for (g = 1; g < 10; g = g + 1) begin : g_src
            pmil_sync u_sync_src (
                .i_clk   (i_clk),
                .i_srst  (i_srst),
                .i_async (src_raw[g]),
                .o_sync  (src_s[g])
            );
        end
    endgenerate
    assign src_s[0] = 1'b0;

    // Edge and deassert conditions; edges held off until syncs fill
    always @(posedge i_clk) begin
        if (i_srst) begin
            src_q  <= 10'h000;
            settle <= 3'h0;
        end else begin
            src_q  <= src_s;
            settle <= {settle[1:0], 1'b1};
        end
    end
    assign rise        = settle[2] ? (src_s & ~src_q) : 10'h000;
    assign fall        = settle[2] ? (~src_s & src_q) : 10'h000;
    assign deassert_ok = ~src_s;

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    assign alt_irq_select = mode_ctrl_status_reg[`PMIL_MODE_ALT_IRQ_SELECT];
    assign rd_flags = rd && (reg_num == `PMIL_REG_FLAGS);
    assign rd_bstat = rd && (reg_num == `PMIL_REG_BSTAT);
    assign rd_anexp = rd && (reg_num == `PMIL_REG_ANEXP);
    assign restart  = wr && (reg_num == `PMIL_REG_BCTL) &&
                      wdata[`PMIL_BCTL_RSTAN];

    // Read mux
    always @* begin
        case (reg_num)
            `PMIL_REG_BCTL:    rdata = basic_control_reg;
            `PMIL_REG_BSTAT:   rdata = `PMIL_BSTAT_FIXED |
                                   {10'h000, i_an_done, i_remote_fault,
                                    1'b0, i_link_state, 2'b01};
            `PMIL_REG_LPABIL:  rdata = {1'b0, i_lp_ack, 14'h0000};
            `PMIL_REG_ANEXP:   rdata = {11'h000, i_pd_fault, 2'b00,
                                        i_page_rx, 1'b0};
            `PMIL_REG_EDPDCFG: rdata = energy_powerdown_cfg_reg;
            `PMIL_REG_MODECS:  rdata = {mode_ctrl_status_reg[15:2],
                                        energy_seen, 1'b0};
            `PMIL_REG_SPECIND: rdata = special_ctrl_status_ind_reg;
            `PMIL_REG_FLAGS:   rdata = irq_flag_reg;
            `PMIL_REG_ENABLES: rdata = irq_enable_reg;
            `PMIL_REG_WAKECS:  rdata = {8'h00, i_wake_ctrl};
            default:           rdata = `PMIL_UNSUP;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable registers; primary mode at reset, strap capture in the first cycle after reset
    always @(posedge i_clk) begin
        if (i_srst) begin
            basic_control_reg           <= `PMIL_BCTL_RESET;
            mode_ctrl_status_reg        <= `PMIL_MODE_RESET;
            special_ctrl_status_ind_reg <= 16'h0000;
            energy_powerdown_cfg_reg    <= 16'h0000;
            irq_enable_reg              <= 16'h0000;
            strap_done                  <= 1'b0;
            hw_xovr_en                  <= 1'b1;
        end else begin
            if (!strap_done) begin
                strap_done <= 1'b1;
                hw_xovr_en <= ~i_xovr_disable[XOVR_DIS_IDX];
            end
            if (wr) begin
                case (reg_num)
                    `PMIL_REG_BCTL:    basic_control_reg <=
                                           wdata & 16'hfdff;
                    `PMIL_REG_MODECS:  mode_ctrl_status_reg <= wdata;
                    `PMIL_REG_SPECIND: special_ctrl_status_ind_reg <= wdata;
                    `PMIL_REG_EDPDCFG: energy_powerdown_cfg_reg <= wdata;
                    `PMIL_REG_ENABLES: irq_enable_reg <=
                                           {6'h00, wdata[9:1], 1'b0};
                    default:           irq_enable_reg <= irq_enable_reg;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Energy status starts high, clears on no signal
    always @(posedge i_clk) begin
        if (i_srst) begin
            energy_seen <= 1'b1;
        end else begin
            energy_seen <= settle[2] ? src_s[`PMIL_F_ENERGY] : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag update: set beats clear in both modes
    always @* begin
        next_flags = irq_flag_reg;
        if (alt_irq_select) begin
            // Write one clears only if deassert condition holds
            if (wr && reg_num == `PMIL_REG_FLAGS) begin
                next_flags = irq_flag_reg &
                    ~({6'h00, wdata[9:1] & deassert_ok[9:1], 1'b0});
            end
        end else begin
            // Falling source clears, except link down
            next_flags[9:1] = irq_flag_reg[9:1] &
                ~(fall[9:1] & 9'h1f7);
            if (rd_flags) begin
                next_flags = 16'h0000;
            end
            if (rd_bstat) begin
                next_flags[`PMIL_F_LDOWN] = 1'b0;
                next_flags[`PMIL_F_RFLT]  = 1'b0;
            end
            if (rd_anexp || restart || rise[`PMIL_F_LDOWN]) begin
                next_flags[`PMIL_F_PAGE] = 1'b0;
                next_flags[`PMIL_F_PDF]  = 1'b0;
            end
        end
        // Event sets, positions fixed by source order
        next_flags[9:1] = next_flags[9:1] | rise[9:1];
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            irq_flag_reg <= 16'h0080;
        end else begin
            irq_flag_reg <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Late energy pulse after cable removal
    always @(posedge i_clk) begin
        if (i_srst) begin
            late_armed <= 1'b0;
            late_cnt   <= 32'h0000_0000;
            pulse_cnt  <= 32'h0000_0000;
        end else begin
            if (irq_enable_reg[`PMIL_F_ENERGY] && src_s[`PMIL_F_ENERGY] &&
                !irq_flag_reg[`PMIL_F_ENERGY]) begin
                late_armed <= 1'b1;
            end else if (!irq_enable_reg[`PMIL_F_ENERGY]) begin
                late_armed <= 1'b0;
            end
            if (late_armed && fall[`PMIL_F_ENERGY]) begin
                late_cnt   <= ELATE_CYC;
                late_armed <= 1'b0;
            end else if (late_cnt != 32'h0000_0000) begin
                late_cnt <= late_cnt - 32'h0000_0001;
                if (late_cnt == 32'h0000_0001) begin
                    pulse_cnt <= EPULSE_CYC;
                end
            end
            if (pulse_cnt != 32'h0000_0000 && late_cnt == 32'h0000_0000) begin
                pulse_cnt <= pulse_cnt - 32'h0000_0001;
            end
        end
    end
    assign pulse_on = (pulse_cnt != 32'h0000_0000);

    ////////////////////////////////////////////////////////////////////////
    // Mode resolution, crossover and interrupt line
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_speed_100   <= 1'b1;
            o_full_duplex <= 1'b1;
            o_crs         <= 1'b0;
            o_col         <= 1'b0;
            o_xovr_enable <= 1'b1;
            o_xovr_state  <= 1'b0;
            o_xovr_extend <= 1'b0;
            o_an_restart  <= 1'b0;
            o_irq         <= 1'b0;
        end else begin
            o_an_restart <= restart;
            if (basic_control_reg[`PMIL_BCTL_ANEN]) begin
                o_speed_100   <= 1'b1;
                o_full_duplex <= 1'b1;
            end else begin
                o_speed_100   <= basic_control_reg[`PMIL_BCTL_SPEED];
                o_full_duplex <= basic_control_reg[`PMIL_BCTL_DUPLEX];
            end
            if (o_full_duplex) begin
                o_crs <= i_rx_active;
                o_col <= 1'b0;
            end else begin
                o_crs <= i_tx_active | i_rx_active;
                o_col <= i_tx_active & i_rx_active;
            end
            if (special_ctrl_status_ind_reg[`PMIL_SPEC_XOVR]) begin
                o_xovr_enable <= special_ctrl_status_ind_reg[`PMIL_SPEC_XEN];
                o_xovr_state  <=
                    special_ctrl_status_ind_reg[`PMIL_SPEC_XSTATE];
            end else begin
                o_xovr_enable <= hw_xovr_en;
                o_xovr_state  <= 1'b0;
            end
            o_xovr_extend <=
                (!basic_control_reg[`PMIL_BCTL_ANEN] &&
                 energy_powerdown_cfg_reg[`PMIL_EDPD_MEXT]) ||
                (mode_ctrl_status_reg[`PMIL_MODE_EDPD] &&
                 energy_powerdown_cfg_reg[`PMIL_EDPD_XEXT]);
            o_irq <= (|(irq_flag_reg[9:1] & irq_enable_reg[9:1])) ||
                     (pulse_on && irq_enable_reg[`PMIL_F_ENERGY]);
        end
    end

endmodule // pmil_top

//--- verif/pmil_top_asserts.sv
// Port assertions of the PHY management logic
module pmil_top_asserts (
    // Clock, reset and watched ports
    input wire i_clk,
    input wire i_srst,
    input wire i_tx_active,
    input wire i_rx_active,
    input wire o_full_duplex,
    input wire o_speed_100,
    input wire o_crs,
    input wire o_col,
    input wire o_irq,
    input wire o_mdio_oe,
    input wire o_an_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////
    // Carrier and collision per duplex mode
    a_crs_full: assert property (!$past(i_srst) && o_full_duplex
        && $past(o_full_duplex) |-> o_crs == $past(i_rx_active))
        else $error("crs wrong in full duplex");
    a_crs_half: assert property (!$past(i_srst) && !o_full_duplex
        && !$past(o_full_duplex)
        |-> o_crs == $past(i_tx_active || i_rx_active))
        else $error("crs wrong in half duplex");
    a_col_half: assert property (!$past(i_srst) && !o_full_duplex
        && !$past(o_full_duplex)
        |-> o_col == $past(i_tx_active && i_rx_active))
        else $error("col wrong in half duplex");
    a_col_full: assert property (o_full_duplex
        && $past(o_full_duplex) |-> !o_col)
        else $error("col seen in full duplex");
    a_col_cause: assert property (o_col
        |-> $past(i_tx_active) && $past(i_rx_active))
        else $error("col without overlap");
    ////////////////////////////////////////////////////////////////
    // Reset state, link turnaround and restart pulse
    a_rst_state: assert property ($past(i_srst)
        |-> !o_irq && o_speed_100 && o_full_duplex)
        else $error("bad state after reset");
    a_oe_hold: assert property ($rose(o_mdio_oe) |-> o_mdio_oe[*8])
        else $error("read drive too short");
    a_rst_pulse: assert property (o_an_restart |=> !o_an_restart)
        else $error("restart pulse too long");
endmodule // pmil_top_asserts

bind pmil_top pmil_top_asserts pmil_top_asserts_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_tx_active(i_tx_active),
    .i_rx_active(i_rx_active), .o_full_duplex(o_full_duplex),
    .o_speed_100(o_speed_100), .o_crs(o_crs), .o_col(o_col),
    .o_irq(o_irq), .o_mdio_oe(o_mdio_oe), .o_an_restart(o_an_restart));

//--- verif/pmil_mgmt_model.sv
// Management controller model driving the serial link
module pmil_mgmt_model (
    // Clock and link
    input  wire  i_clk,
    input  wire  i_mdio_d,
    input  wire  i_mdio_oe,
    output logic o_mdc,
    output wire  o_mdio
);
    timeunit 1ns;
    timeprecision 1ps;
    logic m_oe = 1'b0;
    logic m_bit = 1'b1;
    // Pull-up holds the line high when released
    assign o_mdio = i_mdio_oe ? i_mdio_d : (m_oe ? m_bit : 1'b1);
    initial o_mdc = 1'b0;
    // One link clock period, sampled at the rise
    task automatic tick(output logic s);
        repeat (5) @(posedge i_clk);
        #1 o_mdc = 1'b1;
        s = o_mdio;
        repeat (5) @(posedge i_clk);
        #1 o_mdc = 1'b0;
    endtask
    // Whole frame; link clock stands still after it
    task automatic frame(input logic rd, input logic [4:0] a,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [63:0] f;
        logic        s;
        f = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, a, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            m_oe = !(rd && i < 18);
            m_bit = f[i];
            tick(s);
            q = {q[14:0], s};
        end
        m_oe = 1'b0;
        repeat (20) @(posedge i_clk);
        #1;
    endtask
endmodule // pmil_mgmt_model

//--- verif/pmil_top_tb_top.sv
// Self-checking bench of the PHY management and interrupt logic
`include "pmil_defines.vh"
module pmil_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_srst = 1'b1, i_link_state = 1'b0, i_energy = 1'b1;
    logic i_tx_active = 1'b0, i_rx_active = 1'b0;
    logic i_an_done = 1'b0, i_remote_fault = 1'b0, i_lp_ack = 1'b0;
    logic i_pd_fault = 1'b0, i_page_rx = 1'b0;
    logic [7:0]  i_wake_ctrl = 8'h00;
    logic [1:0]  i_xovr_disable = 2'h0;
    logic [15:0] q, v;
    logic [4:0]  r;
    int          errors = 0, comparisons = 0;
    integer      seed = 32'hafbd_4dde;
    wire i_mdc, i_mdio, o_mdio, o_mdio_oe, o_speed_100, o_full_duplex;
    wire o_crs, o_col, o_xovr_enable, o_xovr_state, o_xovr_extend;
    wire o_an_restart, o_irq;
    pmil_top #(.ELATE_CYC(32'h0000_0032), .EPULSE_CYC(32'h0000_0014))
        pmil_top_inst (.*);
    pmil_mgmt_model pmil_mgmt_model_inst (.i_clk(i_clk), .i_mdio_d(o_mdio),
        .i_mdio_oe(o_mdio_oe), .o_mdc(i_mdc), .o_mdio(i_mdio));
    ////////////////////////////////////////////////////////////////
    // Clock and random MAC activity
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        #1 {i_tx_active, i_rx_active} = 2'($random(seed));
    end
    ////////////////////////////////////////////////////////////////
    // Compare, verdict, link access and bounded wait
    task automatic chk(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        pmil_mgmt_model_inst.frame(1'b1, a, 16'h0000, d);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        pmil_mgmt_model_inst.frame(1'b0, a, d, x);
    endtask
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (o_irq !== e && n < 200) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk("irq", 16'(o_irq), 16'(e));
        if (o_irq !== e)
            end_sim();
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        i_xovr_disable = 2'($random(seed));
        repeat (2) @(posedge i_clk);
        #1 i_srst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 chk("xovr_def", 16'(o_xovr_enable), 16'(!i_xovr_disable[0]));
        rd(`PMIL_REG_FLAGS, q);
        chk("flags_rst", q, 16'h0080);
        rd(`PMIL_REG_FLAGS, q);
        chk("flags_rdclr", q, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            r = (i == 0) ? 5'h1c : {2'b01, 3'($random(seed))};
            rd(r, q);
            chk("unsup", q, `PMIL_UNSUP);
        end
        v = 16'($random(seed)) & 16'h03fe;
        wr(`PMIL_REG_ENABLES, v);
        rd(`PMIL_REG_ENABLES, q);
        chk("enables", q, v);
        wr(`PMIL_REG_ENABLES, 16'h0200);
        i_link_state = 1'b1;
        wait_irq(1'b1);
        rd(`PMIL_REG_FLAGS, q);
        chk("flags_lup", q, 16'h0200);
        wait_irq(1'b0);
        wr(`PMIL_REG_ENABLES, 16'h0100);
        i_wake_ctrl = 8'h84;
        repeat (10) @(posedge i_clk);
        #1 chk("wake_off", 16'(o_irq), 16'h0000);
        i_wake_ctrl = 8'h44;
        wait_irq(1'b1);
        i_wake_ctrl = 8'h00;
        wait_irq(1'b0);
        wr(`PMIL_REG_ENABLES, 16'h0200);
        i_link_state = 1'b0;
        wr(`PMIL_REG_MODECS, 16'h0040);
        i_link_state = 1'b1;
        wait_irq(1'b1);
        rd(`PMIL_REG_FLAGS, q);
        chk("flags_alt", q, 16'h0210);
        wr(`PMIL_REG_FLAGS, 16'h0200);
        chk("alt_keep", 16'(o_irq), 16'h0001);
        i_link_state = 1'b0;
        repeat (10) @(posedge i_clk);
        #1 chk("alt_fall", 16'(o_irq), 16'h0001);
        wr(`PMIL_REG_FLAGS, 16'h0200);
        wait_irq(1'b0);
        for (int i = 0; i < 4; i++) begin
            v = {2'b00, i[1], 4'h0, i[0], 8'h00};
            wr(`PMIL_REG_BCTL, v);
            chk("speed", 16'(o_speed_100), 16'(v[13]));
            chk("duplex", 16'(o_full_duplex), 16'(v[8]));
            wr(`PMIL_REG_BCTL, v | 16'h1200);
            chk("an_mode", 16'({o_speed_100, o_full_duplex}), 16'h0003);
        end
        v = {3'($random(seed)), 13'h0000} | 16'h8000;
        wr(`PMIL_REG_SPECIND, v);
        chk("xovr", 16'({o_xovr_enable, o_xovr_state}), 16'(v[14:13]));
        wr(`PMIL_REG_BCTL, 16'h0000);
        wr(`PMIL_REG_EDPDCFG, 16'h0002);
        chk("ext_man", 16'(o_xovr_extend), 16'h0001);
        wr(`PMIL_REG_EDPDCFG, 16'h0001);
        chk("ext_off", 16'(o_xovr_extend), 16'h0000);
        wr(`PMIL_REG_MODECS, 16'h2040);
        chk("ext_edpd", 16'(o_xovr_extend), 16'h0001);
        // Late energy pulse: armed, then cable pulled
        wr(`PMIL_REG_ENABLES, 16'h0080);
        i_energy = 1'b0;
        repeat (20) @(posedge i_clk);
        #1 chk("elate_early", 16'(o_irq), 16'h0000);
        wait_irq(1'b1);
        wait_irq(1'b0);
        end_sim();
    end
endmodule // pmil_top_tb_top
